// *** inc/svtm_pkg.sv ***
// Purpose: shared constants and types of the supply voltage trip monitor
// Assumes: AXI4-Lite register access, 32-bit data, 100 MHz aclk
// Notes: one word per register; narrow registers sit in the low bits
package svtm_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] MASK_OFS = 4'h8;

  // voltage_monitor_control field positions
  localparam int LEVEL_LSB = 0;
  localparam int LEVEL_W = 4;
  localparam int PWR_EN_BIT = 4;
  localparam int REF_STABLE_BIT = 5;
  localparam int BG_STABLE_BIT = 6;
  localparam int DIR_BIT = 7;

  // status and mask field position
  localparam int TRIP_EVENT_BIT = 0;

  // reset values, and the level code that selects the external input
  localparam logic [LEVEL_W-1:0] LEVEL_RST = 4'h5;
  localparam logic PWR_EN_RST = 1'b0;
  localparam logic DIR_RST = 1'b0;
  localparam logic MASK_RST = 1'b0;
  localparam logic [LEVEL_W-1:0] LEVEL_EXTERNAL = 4'hf;

  // reference settling time after power-up, in ns
  localparam int SETTLE_NS = 5000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_CYC =
    (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CNT_W = 10;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // register select codes
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_STATUS = 2'h1;
  localparam logic [1:0] SEL_MASK = 2'h2;
  localparam logic [1:0] SEL_NONE = 2'h3;

  typedef enum logic [1:0] {
    REF_OFF,
    REF_SETTLE,
    REF_STABLE
  } svtm_ref_state_type;

endpackage

// *** hw/svtm_top.sv ***
// Purpose: control and status logic of the supply voltage trip monitor
// Assumes: analog comparator and band gap status arrive asynchronously
// Notes: registers reached over AXI4-Lite; one interrupt level output
//
// Overview of operation
// - trip in the selected direction sets the event flag, and the interrupt when the mask bit is set
// - direction bit 7: clear detects falling, set detects rising
// - power enable bit 4 switches the monitor circuitry on or off
// - reference-stable bit 5 reads zero after each power-up until settled
// - no event flag is raised while reference-stable reads zero
// - monitor results are untrusted until reference-stable reads one
// - configuration, enable and reference status live in the control register; event flag and mask have their own
// - level field gives sixteen trip points including external input
// - any reset returns control to reset state, monitor off
// - monitor keeps working while enabled; a trip flags, and wakes only when the mask bit is set
module svtm_top (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [svtm_pkg::ADDR_W-1:0] awaddr,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [svtm_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [svtm_pkg::ADDR_W-1:0] araddr,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [svtm_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  // analog side
  input wire logic supply_above_trip,
  input wire logic bandgap_ready,
  output logic monitor_power_enable,
  output logic trip_direction_select,
  output logic [svtm_pkg::LEVEL_W-1:0] trip_level_select,
  output logic external_trip_input_select,
  // interrupt, also the wake request
  output logic trip_irq
);
  import svtm_pkg::*;

  function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [1:0] s;
    s = SEL_NONE;
    if (a == CTRL_OFS) begin
      s = SEL_CTRL;
    end else if (a == STATUS_OFS) begin
      s = SEL_STATUS;
    end else if (a == MASK_OFS) begin
      s = SEL_MASK;
    end
    return s;
  endfunction

  // bus state
  logic aw_held_q, aw_held_d;
  logic w_held_q, w_held_d;
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic [DATA_W-1:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  // monitor state
  logic dir_q, dir_d;
  logic pwr_en_q, pwr_en_d;
  logic [LEVEL_W-1:0] level_q, level_d;
  logic flag_q, flag_d;
  logic mask_q, mask_d;
  svtm_ref_state_type ref_q, ref_d;
  logic [SETTLE_CNT_W-1:0] cnt_q, cnt_d;
  logic ext_sel_q, ext_sel_d;
  logic irq_q, irq_d;

  // synchronisers
  logic cmp_meta_q, cmp_sync_q;
  logic bg_meta_q, bg_sync_q;

  // write path
  wire aw_take = awvalid && awready;
  wire w_take = wvalid && wready;
  wire wr_fire = aw_held_q && w_held_q && !bvalid_q;
  wire [1:0] wr_sel = reg_sel(aw_addr_q);
  wire wr_lane0 = wr_fire && w_strb_q[0];
  wire wr_ctrl = wr_lane0 && (wr_sel == SEL_CTRL);
  wire wr_status = wr_lane0 && (wr_sel == SEL_STATUS);
  wire wr_mask = wr_lane0 && (wr_sel == SEL_MASK);

  // read path
  wire ar_take = arvalid && arready;
  wire [1:0] rd_sel = reg_sel(araddr);
  wire ref_stable = (ref_q == REF_STABLE);
  wire [7:0] ctrl_word = {dir_q, bg_sync_q, ref_stable, pwr_en_q,
                          level_q};
  wire [DATA_W-1:0] ctrl_rd = {24'h000000, ctrl_word};
  wire [DATA_W-1:0] status_rd = {31'h00000000, flag_q};
  wire [DATA_W-1:0] mask_rd = {31'h00000000, mask_q};
  wire [DATA_W-1:0] rd_word =
    (rd_sel == SEL_CTRL) ? ctrl_rd :
    (rd_sel == SEL_STATUS) ? status_rd :
    (rd_sel == SEL_MASK) ? mask_rd : 32'h00000000;

  // handshake outputs
  assign awready = !aw_held_q;
  assign wready = !w_held_q;
  assign arready = !rvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // analog controls come straight from control flops
  assign monitor_power_enable = pwr_en_q;
  assign trip_direction_select = dir_q;
  assign trip_level_select = level_q;
  // registered so the analog input mux select never glitches
  assign ext_sel_d = (level_d == LEVEL_EXTERNAL);
  assign external_trip_input_select = ext_sel_q;

  // level detect in the chosen direction, gated by a settled reference
  wire trip_cond = dir_q ? cmp_sync_q : !cmp_sync_q;
  wire trip_set = pwr_en_q && ref_stable && trip_cond;
  wire flag_clr = wr_status && w_data_q[TRIP_EVENT_BIT];

  // set wins over a simultaneous software clear
  assign flag_d = trip_set || (flag_q && !flag_clr);
  assign mask_d = wr_mask ? w_data_q[TRIP_EVENT_BIT] : mask_q;
  assign irq_d = flag_d && mask_d;
  assign trip_irq = irq_q;

  // control register writes; read-only bits 5 and 6 ignore writes
  assign dir_d = wr_ctrl ? w_data_q[DIR_BIT] : dir_q;
  assign pwr_en_d = wr_ctrl ? w_data_q[PWR_EN_BIT] : pwr_en_q;
  assign level_d = wr_ctrl ?
    w_data_q[LEVEL_LSB +: LEVEL_W] : level_q;

  // reference settle tracking; any power-down restarts it
  wire cnt_done = (cnt_q == SETTLE_CNT_W'(SETTLE_CYC - 1));

  always_comb begin
    ref_d = ref_q;
    cnt_d = cnt_q;
    case (ref_q)
      REF_OFF: begin
        cnt_d = '0;
        if (pwr_en_q) begin
          ref_d = REF_SETTLE;
        end
      end
      REF_SETTLE: begin
        cnt_d = cnt_q + SETTLE_CNT_W'(1);
        if (!pwr_en_q) begin
          ref_d = REF_OFF;
        end else if (cnt_done) begin
          ref_d = REF_STABLE;
        end
      end
      REF_STABLE: begin
        if (!pwr_en_q) begin
          ref_d = REF_OFF;
        end
      end
      default: begin
        ref_d = REF_OFF;
      end
    endcase
  end

  // bus next state
  always_comb begin
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d = w_held_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (aw_take) begin
      aw_held_d = 1'b1;
      aw_addr_d = awaddr;
    end
    if (w_take) begin
      w_held_d = 1'b1;
      w_data_d = wdata;
      w_strb_d = wstrb;
    end
    if (wr_fire) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
  end

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (ar_take) begin
      rvalid_d = 1'b1;
      rdata_d = rd_word;
      rresp_d = (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
  end

  // two-flop synchronisers for asynchronous analog status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_meta_q <= 1'b0;
      cmp_sync_q <= 1'b0;
      bg_meta_q <= 1'b0;
      bg_sync_q <= 1'b0;
    end else begin
      cmp_meta_q <= supply_above_trip;
      cmp_sync_q <= cmp_meta_q;
      bg_meta_q <= bandgap_ready;
      bg_sync_q <= bg_meta_q;
    end
  end

  // monitor registers; reset leaves the monitor off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_q <= DIR_RST;
      pwr_en_q <= PWR_EN_RST;
      level_q <= LEVEL_RST;
      flag_q <= 1'b0;
      mask_q <= MASK_RST;
      ref_q <= REF_OFF;
      cnt_q <= '0;
      ext_sel_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      dir_q <= dir_d;
      pwr_en_q <= pwr_en_d;
      level_q <= level_d;
      flag_q <= flag_d;
      mask_q <= mask_d;
      ref_q <= ref_d;
      cnt_q <= cnt_d;
      // loaded from the same next values, so no extra cycle of lag
      ext_sel_q <= ext_sel_d;
      irq_q <= irq_d;
    end
  end

  // bus registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q <= w_held_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

endmodule // svtm_top

// *** tb/svtm_asserts.sv ***
// Purpose: port checks of the supply trip monitor
// Assumes: one clock, synchronous active-low reset
// Notes: bound from the bench top file
module svtm_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [svtm_pkg::DATA_W-1:0] rdata,
  input wire logic monitor_power_enable,
  input wire logic trip_direction_select,
  input wire logic [svtm_pkg::LEVEL_W-1:0] trip_level_select,
  input wire logic external_trip_input_select,
  input wire logic trip_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dcb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_ext_decode: assert property (
    external_trip_input_select == (trip_level_select == 4'hf))
    else $error("external select decode wrong");
  a_reset_state: assert property ($rose(aresetn) |->
    !monitor_power_enable && trip_level_select == 4'h5 && !trip_irq)
    else $error("control not at reset state");
  // irq only drops through a register write
  a_irq_fall: assert property ($fell(trip_irq) |-> $rose(bvalid))
    else $error("irq dropped without a write");
  a_cfg_write: assert property ($past(aresetn) &&
    ($changed(trip_level_select) || $changed(monitor_power_enable) ||
    $changed(trip_direction_select)) |-> $rose(bvalid))
    else $error("config changed without a write");
  a_write_answer: assert property (
    awvalid && awready && wvalid && wready && !bvalid |-> ##2 bvalid)
    else $error("write response late");
  a_bresp_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response not held");
  a_rdata_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  a_read_answer: assert property (
    arvalid && arready |=> rvalid ##0 !arready)
    else $error("read answer late");
endmodule // svtm_asserts

// *** tb/svtm_tb.sv ***
// Purpose: self-checking bench of the supply trip monitor
// Assumes: 100 MHz aclk, full settle time of the reference
// Notes: comparator and band gap inputs driven directly
module svtm_tb import svtm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, done;
  logic supply_above_trip = 1'b1, bandgap_ready = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic [31:0] wdata = 32'h0, rdata, got;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid, monitor_power_enable;
  logic trip_direction_select, external_trip_input_select, trip_irq;
  logic [3:0] trip_level_select;
  int err_total = 0;
  int checks_done = 0;
  svtm_top svtm_top_inst (.aclk, .aresetn, .awvalid, .awready, .awaddr,
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .supply_above_trip,
    .bandgap_ready, .monitor_power_enable, .trip_direction_select,
    .trip_level_select, .external_trip_input_select, .trip_irq);
  initial forever #5 aclk = ~aclk;
  task automatic complete_run();
    if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic hang(input int n);
    if (n >= 400) begin
      err_total++;
      complete_run();
    end
  endtask
  // ready rides with the request; the answer is taken at its valid edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      done = bvalid;
      resp = bresp;
    end while (!done && n < 400);
    bready <= 1'b0;
    hang(n);
  endtask
  task automatic rd(input logic [3:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      done = rvalid;
      got = rdata;
      resp = rresp;
    end while (!done && n < 400);
    rready <= 1'b0;
    hang(n);
  endtask
  task automatic settle(input logic [31:0] e);
    int n;
    n = 0;
    do begin
      rd(CTRL_OFS);
      n++;
    end while (got[REF_STABLE_BIT] !== 1'b1 && n < 400);
    hang(n);
    chk(got, e);
  endtask
  task automatic t_reset();
    rd(CTRL_OFS);
    chk(got, 32'h5);
    chk(resp, RESP_OKAY);
    rd(STATUS_OFS);
    chk(got, 32'h0);
    rd(MASK_OFS);
    chk(got, 32'h0);
    chk({monitor_power_enable, trip_level_select}, 5'h05);
    chk({trip_direction_select, external_trip_input_select, trip_irq},
        3'h0);
  endtask
  task automatic t_unmapped();
    wr(4'hc, 32'hff);
    chk(resp, RESP_SLVERR);
    rd(4'hc);
    chk(got, 32'h0);
    chk(resp, RESP_SLVERR);
    // lane 0 off: control must stay as it was
    wstrb <= 4'he;
    wr(CTRL_OFS, 32'h9f);
    chk(resp, RESP_OKAY);
    wstrb <= 4'hf;
    rd(CTRL_OFS);
    chk(got, 32'h5);
  endtask
  task automatic t_levels();
    for (int i = 0; i < 16; i++) begin
      wr(CTRL_OFS, {28'h8, i[3:0]});
      rd(CTRL_OFS);
      chk(got, {28'h8, i[3:0]});
      chk(external_trip_input_select, i == 15);
      chk({trip_direction_select, trip_level_select}, {1'b1, i[3:0]});
    end
  endtask
  task automatic t_monitor();
    bandgap_ready <= 1'b1;
    wr(CTRL_OFS, 32'h15);
    chk(monitor_power_enable, 1'b1);
    supply_above_trip <= 1'b0;
    rd(CTRL_OFS);
    chk(got, 32'h55);
    repeat (400) @(posedge aclk);
    rd(STATUS_OFS);
    chk(got, 32'h0);
    settle(32'h75);
    rd(STATUS_OFS);
    chk(got, 32'h1);
    wr(MASK_OFS, 32'h1);
    chk(trip_irq, 1'b1);
    supply_above_trip <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(STATUS_OFS);
    chk(got, 32'h1);
    wr(STATUS_OFS, 32'h1);
    chk(trip_irq, 1'b0);
    wr(CTRL_OFS, 32'h05);
    chk(monitor_power_enable, 1'b0);
    wr(CTRL_OFS, 32'h95);
    rd(CTRL_OFS);
    chk(got, 32'hd5);
    settle(32'hf5);
    repeat (4) @(posedge aclk);
    chk(trip_irq, 1'b1);
    wr(MASK_OFS, 32'h0);
    chk(trip_irq, 1'b0);
    bandgap_ready <= 1'b0;
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_unmapped();
    t_levels();
    t_monitor();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    complete_run();
  end
endmodule // svtm_tb
bind svtm_top svtm_asserts svtm_asserts_inst (.aclk, .aresetn, .awvalid,
  .awready, .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready,
  .rvalid, .rready, .rdata, .monitor_power_enable, .trip_direction_select,
  .trip_level_select, .external_trip_input_select, .trip_irq);
